/* File: rtl/pmc_pkg.sv */
/*
 * Shared constants and types for the power management control/status block:
 * register offsets, field positions, reset values and power state codes.
 * Assumes a single clock domain and a plain address/strobe register port.
 */
package pmc_pkg;

    // -------------------------------------------------------------------
    // Register offsets on the register port.
    // -------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS      = 8'hA4;  // Control/status register.
    localparam logic [7:0]  BSE_OFS       = 8'hA6;  // Bridge support extensions.
    localparam logic [7:0]  IRQ_STAT_OFS  = 8'hB0;  // Sticky event status.
    localparam logic [7:0]  IRQ_MASK_OFS  = 8'hB2;  // Event mask, 1 enables.

    // -------------------------------------------------------------------
    // Field positions and reset values.
    // -------------------------------------------------------------------
    localparam int          WAKE_STAT_BIT = 15;     // Wake status flag.
    localparam int          WAKE_EN_BIT   = 8;      // Wake assert enable.
    localparam logic [15:0] CTRL_RESET    = 16'h0000; // Control/status reset.
    localparam logic [15:0] CTRL_ZERO_MASK = 16'h7EFC; // Bits that read zero.
    localparam logic [7:0]  BSE_VALUE     = 8'hC0;  // Fixed extension value.
    localparam int          BSE_BPCC_BIT  = 7;      // Bus power/clock enable.
    localparam int          BSE_SLEEP_BIT = 6;      // Secondary sleep select.
    localparam logic [15:0] READ_IDLE     = 16'h0000; // Unmapped / idle data.

    // -------------------------------------------------------------------
    // Interrupt status layout.
    // -------------------------------------------------------------------
    localparam int          IRQ_W         = 3;      // Number of event bits.
    localparam int          IRQ_WAKE      = 0;      // Wake request seen.
    localparam int          IRQ_PSTATE    = 1;      // Power state changed.
    localparam int          IRQ_FRESET    = 2;      // D3hot to D0 reset fired.
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;  // Status and mask reset.

    // -------------------------------------------------------------------
    // Power state encoding in the register and the one-hot state type.
    // -------------------------------------------------------------------
    localparam logic [1:0]  PS_D0  = 2'h0;          // Fully on.
    localparam logic [1:0]  PS_D1  = 2'h1;          // Light sleep.
    localparam logic [1:0]  PS_D2  = 2'h2;          // Deeper sleep.
    localparam logic [1:0]  PS_D3H = 2'h3;          // D3hot.

    typedef enum logic [3:0] {
        PMC_ST_D0  = 4'h1,
        PMC_ST_D1  = 4'h2,
        PMC_ST_D2  = 4'h4,
        PMC_ST_D3H = 4'h8
    } pmc_pstate_t;

    // Write-one-to-clear with a set that wins over the clear.
    function automatic logic [15:0] pmc_w1c(input logic [15:0] cur,
                                            input logic [15:0] clr,
                                            input logic [15:0] set);
        pmc_w1c = (cur & ~clr) | set;
    endfunction

endpackage

/* File: rtl/pmc_pwr_if.sv */
/*
 * Carrier between the register block and the power state tracker.
 * Assumes both ends share one clock and one synchronous reset.
 */
`timescale 1ns/1ps
interface pmc_pwr_if;
    logic       wr_valid;   // Power state field written this cycle.
    logic [1:0] wr_state;   // Written power state code.
    logic       bus_power_clock_ctrl_enable;  // Bus power/clock control enabled.
    logic       sleep_sel;  // 1 stops secondary clock, 0 removes power.
    logic [1:0] cur_state;  // Current power state code.
    logic       leave_d3;   // One-cycle pulse on D3hot to D0.
    logic       clk_stop;   // Secondary bus clock stopped.
    logic       pwr_off;    // Secondary bus power removed.

    modport regs (output wr_valid, wr_state, bus_power_clock_ctrl_enable, sleep_sel,
                  input  cur_state, leave_d3, clk_stop, pwr_off);
    modport fsm  (input  wr_valid, wr_state, bus_power_clock_ctrl_enable, sleep_sel,
                  output cur_state, leave_d3, clk_stop, pwr_off);
endinterface // pmc_pwr_if

/* File: rtl/pmc_power_fsm.sv */
/*
 * Power state tracker with the secondary bus sleep policy.
 * Assumes writes arrive as one-cycle strobes from the register block.
 */
`timescale 1ns/1ps
module pmc_power_fsm (
    input  wire logic core_clk_in,  // System clock.
    input  wire logic reset_in,     // Synchronous reset, active high.
    pmc_pwr_if.fsm    pif           // Link to the register block.
);

    // -------------------------------------------------------------------
    // State register.
    // -------------------------------------------------------------------
    pmc_pkg::pmc_pstate_t state;       // Current one-hot state.
    pmc_pkg::pmc_pstate_t next_state;  // Decoded written state.
    logic                 next_d3;     // Next state is D3hot.

    // Decode the written code into the one-hot state.
    always_comb begin
        case (pif.wr_state)
            pmc_pkg::PS_D0:  next_state = pmc_pkg::PMC_ST_D0;
            pmc_pkg::PS_D1:  next_state = pmc_pkg::PMC_ST_D1;
            pmc_pkg::PS_D2:  next_state = pmc_pkg::PMC_ST_D2;
            default:         next_state = pmc_pkg::PMC_ST_D3H;
        endcase
        next_d3 = (pif.wr_valid ? next_state : state) == pmc_pkg::PMC_ST_D3H;
    end

    // The state moves to whatever software writes.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state <= pmc_pkg::PMC_ST_D0;
        end else if (pif.wr_valid) begin
            state <= next_state;
        end
    end

    // Leaving D3hot for D0 fires the function's internal reset.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pif.leave_d3 <= 1'b0;
        end else begin
            pif.leave_d3 <= pif.wr_valid && (state == pmc_pkg::PMC_ST_D3H)
                            && (next_state == pmc_pkg::PMC_ST_D0);
        end
    end

    // Sleep the secondary bus in D3hot, only when the policy is enabled.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pif.clk_stop <= 1'b0;
            pif.pwr_off  <= 1'b0;
        end else begin
            pif.clk_stop <= pif.bus_power_clock_ctrl_enable && next_d3 && pif.sleep_sel;
            pif.pwr_off  <= pif.bus_power_clock_ctrl_enable && next_d3 && !pif.sleep_sel;
        end
    end

    // Report the state in the register encoding.
    always_comb begin
        case (state)
            pmc_pkg::PMC_ST_D0:  pif.cur_state = pmc_pkg::PS_D0;
            pmc_pkg::PMC_ST_D1:  pif.cur_state = pmc_pkg::PS_D1;
            pmc_pkg::PMC_ST_D2:  pif.cur_state = pmc_pkg::PS_D2;
            default:             pif.cur_state = pmc_pkg::PS_D3H;
        endcase
    end

endmodule // pmc_power_fsm

/* File: rtl/pmc_regs.sv */
/*
 * Power management control/status register bank for one bridge function,
 * with wake signalling, secondary bus sleep policy and an event interrupt.
 * Assumes one clock, a synchronous reset and a register master that never
 * issues a read and a write in the same cycle.
 */
`timescale 1ns/1ps
module pmc_regs (
    input  wire logic        core_clk_in,        // System clock, 50 MHz.
    input  wire logic        reset_in,           // Synchronous reset, active high.
    input  wire logic [7:0]  addr_in,            // Register byte offset.
    input  wire logic [15:0] wr_data_in,         // Write data.
    input  wire logic        wr_strobe_in,       // One-cycle write strobe.
    input  wire logic        rd_strobe_in,       // One-cycle read strobe.
    input  wire logic        wake_event_in,      // Function wants to wake.
    output logic      [15:0] rd_data_out,        // Read data, one cycle later.
    output logic             wake_n_out,         // Wake request, active low.
    output logic             func_reset_out,     // Internal reset pulse.
    output logic             sec_clk_stop_out,   // Secondary clock stopped.
    output logic             sec_power_off_out,  // Secondary power removed.
    output logic             irq_out             // Level interrupt.
);

    // -------------------------------------------------------------------
    // Power state tracker.
    // -------------------------------------------------------------------
    pmc_pwr_if pif ();  // Carrier to the tracker.

    pmc_power_fsm pmc_power_fsm_inst (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .pif         (pif)
    );

    // -------------------------------------------------------------------
    // Register state.
    // -------------------------------------------------------------------
    localparam int IRQW = pmc_pkg::IRQ_W;  // Local alias of the width.

    logic             wake_flag;       // Sticky wake status flag.
    logic             wake_en;         // Wake assert enable.
    logic [IRQW-1:0]  irq_stat;        // Sticky event status.
    logic [IRQW-1:0]  irq_mask;        // Event mask.
    logic             next_wake_flag;  // Next wake flag.
    logic             next_wake_en;    // Next wake enable.
    logic [IRQW-1:0]  next_irq_stat;   // Next event status.
    logic [IRQW-1:0]  next_irq_mask;   // Next event mask.
    logic [IRQW-1:0]  irq_events;      // Events of this cycle.
    logic             wr_ctrl;         // Write to control/status.
    logic             wr_stat;         // Write to event status.
    logic             wr_mask;         // Write to event mask.
    logic [15:0]      stat_wide;       // Status widened for the helper.

    // -------------------------------------------------------------------
    // Address decode.
    // -------------------------------------------------------------------
    // Each write lands on at most one register; unmapped and extension register writes are dropped.
    always_comb begin
        wr_ctrl  = wr_strobe_in && (addr_in == pmc_pkg::CTRL_OFS);
        wr_stat  = wr_strobe_in && (addr_in == pmc_pkg::IRQ_STAT_OFS);
        wr_mask  = wr_strobe_in && (addr_in == pmc_pkg::IRQ_MASK_OFS);
    end

    // -------------------------------------------------------------------
    // Tracker requests and fixed bridge policy.
    // -------------------------------------------------------------------
    // The extension register is read-only, so the policy bits are fixed.
    // Gating through bus_power_clock_ctrl_enable keeps the sleep select inert if the enable
    // were ever cleared, at the cost of one constant AND.
    always_comb begin
        pif.wr_valid  = wr_ctrl;
        pif.wr_state  = wr_data_in[1:0];
        pif.bus_power_clock_ctrl_enable = pmc_pkg::BSE_VALUE[pmc_pkg::BSE_BPCC_BIT];
        pif.sleep_sel = pmc_pkg::BSE_VALUE[pmc_pkg::BSE_SLEEP_BIT];
    end

    // -------------------------------------------------------------------
    // Wake status and enable.
    // -------------------------------------------------------------------
    // The flag is set by the request whether enabled or not, and a
    // request in the clearing cycle wins so no wake is ever lost.
    always_comb begin
        next_wake_flag = wake_flag;
        next_wake_en   = wake_en;
        if (wr_ctrl) begin
            next_wake_en = wr_data_in[pmc_pkg::WAKE_EN_BIT];
            if (wr_data_in[pmc_pkg::WAKE_STAT_BIT]) begin
                next_wake_flag = 1'b0;
            end
        end
        if (wake_event_in) begin
            next_wake_flag = 1'b1;
        end
    end

    // The internal reset pulse is deliberately not an input here, so the
    // control/status contents ride through the D3hot to D0 transition.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wake_flag <= pmc_pkg::CTRL_RESET[pmc_pkg::WAKE_STAT_BIT];
            wake_en   <= pmc_pkg::CTRL_RESET[pmc_pkg::WAKE_EN_BIT];
        end else begin
            wake_flag <= next_wake_flag;
            wake_en   <= next_wake_en;
        end
    end

    // Wake output follows the next values so it tracks the register.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wake_n_out <= 1'b1;
        end else begin
            wake_n_out <= !(next_wake_flag && next_wake_en);
        end
    end

    // -------------------------------------------------------------------
    // Event interrupt.
    // -------------------------------------------------------------------
    // Events: a wake request, any accepted power state change and the
    // internal reset pulse. Status is write-one-to-clear, set wins.
    always_comb begin
        irq_events = '0;
        irq_events[pmc_pkg::IRQ_WAKE]   = wake_event_in;
        irq_events[pmc_pkg::IRQ_PSTATE] = wr_ctrl
                                          && (wr_data_in[1:0] != pif.cur_state);
        irq_events[pmc_pkg::IRQ_FRESET] = pif.leave_d3;
        stat_wide = pmc_pkg::pmc_w1c({13'h0000, irq_stat},
                                     wr_stat ? {13'h0000, wr_data_in[IRQW-1:0]}
                                             : 16'h0000,
                                     {13'h0000, irq_events});
        next_irq_stat = stat_wide[IRQW-1:0];
        next_irq_mask = wr_mask ? wr_data_in[IRQW-1:0] : irq_mask;
    end

    // Status and mask registers.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_stat <= pmc_pkg::IRQ_RESET;
            irq_mask <= pmc_pkg::IRQ_RESET;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
        end
    end

    // Interrupt level from next values, so it drops with the clear.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(next_irq_stat & next_irq_mask);
        end
    end

    // -------------------------------------------------------------------
    // Read port.
    // -------------------------------------------------------------------
    // Data stand for one cycle after the strobe, zero otherwise. Fields
    // with no storage (data scale, data select, dynamic data enable and
    // the reserved bits) are driven from zero constants, so they read as zero.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rd_data_out <= pmc_pkg::READ_IDLE;
        end else if (rd_strobe_in) begin
            case (addr_in)
                pmc_pkg::CTRL_OFS: begin
                    rd_data_out <= {wake_flag, 6'h00, wake_en,
                                    6'h00, pif.cur_state};
                end
                pmc_pkg::BSE_OFS: begin
                    rd_data_out <= {8'h00, pmc_pkg::BSE_VALUE};
                end
                pmc_pkg::IRQ_STAT_OFS: begin
                    rd_data_out <= {13'h0000, irq_stat};
                end
                pmc_pkg::IRQ_MASK_OFS: begin
                    rd_data_out <= {13'h0000, irq_mask};
                end
                default: begin
                    rd_data_out <= pmc_pkg::READ_IDLE;
                end
            endcase
        end else begin
            rd_data_out <= pmc_pkg::READ_IDLE;
        end
    end

    // -------------------------------------------------------------------
    // Outputs taken from the tracker's flip-flops.
    // -------------------------------------------------------------------
    // The pulse resets the standard, socket and bus registers that live
    // outside this bank; everything kept here is preserved.
    assign func_reset_out    = pif.leave_d3;
    assign sec_clk_stop_out  = pif.clk_stop;
    assign sec_power_off_out = pif.pwr_off;

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // A read of the control/status register.
    sequence s_ctrl_read;
        rd_strobe_in && addr_in == pmc_pkg::CTRL_OFS;
    endsequence

    // A write taking the function from D3hot to D0.
    sequence s_leave_d3;
        wr_ctrl && pif.cur_state == pmc_pkg::PS_D3H
        && wr_data_in[1:0] == pmc_pkg::PS_D0;
    endsequence

    // The internal reset is high for one cycle.
    sequence s_one_pulse;
        func_reset_out ##1 !func_reset_out;
    endsequence

    // A clear right after the request may drop the flag.
    property p_wake_set;
        wake_event_in |=> wake_flag ##1 (wake_flag || $past(wr_ctrl));
    endproperty
    a_wake_set: assert property (p_wake_set)
        else $error("Wake request did not set the flag.");

    property p_wake_clear;
        (wr_ctrl && wr_data_in[pmc_pkg::WAKE_STAT_BIT] && !wake_event_in)
        |=> !wake_flag && wake_n_out;
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("Writing one did not clear the wake flag.");

    property p_wake_keep;
        (wr_ctrl && !wr_data_in[pmc_pkg::WAKE_STAT_BIT] && wake_flag)
        |=> wake_flag;
    endproperty
    a_wake_keep: assert property (p_wake_keep)
        else $error("Writing zero changed the wake flag.");

    property p_wake_gate;
        !wake_n_out |-> wake_flag && wake_en;
    endproperty
    a_wake_gate: assert property (p_wake_gate)
        else $error("Wake driven without flag and enable.");

    property p_read_zero;
        s_ctrl_read |=> (rd_data_out & pmc_pkg::CTRL_ZERO_MASK) == 16'h0000
                         && rd_data_out[1:0] == pif.cur_state;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("Zero fields of control/status read nonzero.");

    property p_bse_read;
        (rd_strobe_in && addr_in == pmc_pkg::BSE_OFS) |=> rd_data_out == 16'h00C0;
    endproperty
    a_bse_read: assert property (p_bse_read)
        else $error("Extension register read wrong value.");

    property p_state_set;
        wr_ctrl |=> pif.cur_state == $past(wr_data_in[1:0]);
    endproperty
    a_state_set: assert property (p_state_set)
        else $error("Power state did not follow the write.");

    property p_freset;
        s_leave_d3 |=> s_one_pulse;
    endproperty
    a_freset: assert property (p_freset)
        else $error("D3hot to D0 did not give one reset pulse.");

    property p_keep_on_reset;
        func_reset_out && !wr_ctrl |=> wake_en == $past(wake_en)
                                        && pif.cur_state == pmc_pkg::PS_D0;
    endproperty
    a_keep_on_reset: assert property (p_keep_on_reset)
        else $error("Internal reset disturbed control/status.");

    property p_sleep;
        pif.cur_state == pmc_pkg::PS_D3H |-> sec_clk_stop_out && !sec_power_off_out;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("D3hot did not stop the secondary clock.");

    property p_awake;
        pif.cur_state != pmc_pkg::PS_D3H |-> !sec_clk_stop_out && !sec_power_off_out;
    endproperty
    a_awake: assert property (p_awake)
        else $error("Secondary bus asleep outside D3hot.");

    // Enable bit 8 is plain read/write storage.
    property p_en_write;
        wr_ctrl |=> wake_en == $past(wr_data_in[pmc_pkg::WAKE_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("Wake enable did not follow the write.");

    // Flag and enable together must drive the wake output.
    property p_wake_drive;
        wake_flag && wake_en |-> !wake_n_out;
    endproperty
    a_wake_drive: assert property (p_wake_drive)
        else $error("Wake not driven with flag and enable set.");

    // -------------------------------------------------------------------
    // Read port and interrupt checks.
    // -------------------------------------------------------------------
    // Data stand one cycle only, so stale data never leak.
    property p_rd_idle;
        !rd_strobe_in |=> rd_data_out == pmc_pkg::READ_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("Read data stood without a read strobe.");

    // A wake request always lands in the event status.
    property p_irq_wake;
        wake_event_in |=> irq_stat[pmc_pkg::IRQ_WAKE];
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("Wake request missed the event status.");

    // The level tracks status and mask in the same cycle.
    property p_irq_level;
        irq_out == |(irq_stat & irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt level disagrees with status and mask.");

endmodule // pmc_regs

/* File: dv/pmc_regs_bench.sv */
/*
 * Self-checking bench for the power management register bank: register
 * reads and writes, power state moves, wake signalling and the interrupt.
 * Assumes the bench alone drives the register port and the wake input.
 */
`timescale 1ns/1ps
module pmc_regs_bench;
    // ---------------------------------------------------------------
    // Signals and the design under test.
    // ---------------------------------------------------------------
    logic        core_clk_in;     // Bench clock, 50 MHz.
    logic        reset_in;        // Synchronous reset, active high.
    logic [7:0]  addr_in;         // Register offset.
    logic [15:0] wr_data_in;      // Write data.
    logic        wr_strobe_in;    // Write strobe.
    logic        rd_strobe_in;    // Read strobe.
    logic        wake_event_in;   // Wake request from the function.
    logic [15:0] rd_data_out;     // Read data.
    logic        wake_n_out;      // Wake output, active low.
    logic        func_reset_out;  // Internal reset pulse.
    logic        sec_clk_stop_out;   // Secondary clock stopped.
    logic        sec_power_off_out;  // Secondary power removed.
    logic        irq_out;         // Level interrupt.
    int          err_count = 0;   // Mismatches seen.
    int          n_tests = 0;     // Comparisons made.
    int          cycles = 0;      // Cycles since start, for the timeout.

    pmc_regs pmc_regs_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
        .rd_strobe_in(rd_strobe_in), .wake_event_in(wake_event_in),
        .rd_data_out(rd_data_out), .wake_n_out(wake_n_out),
        .func_reset_out(func_reset_out), .sec_clk_stop_out(sec_clk_stop_out),
        .sec_power_off_out(sec_power_off_out), .irq_out(irq_out));

    // ---------------------------------------------------------------
    // Clock and timeout.
    // ---------------------------------------------------------------
    // The whole run takes under a hundred cycles, so 5000 only trips on a hang.
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            end_sim();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks.
    // ---------------------------------------------------------------
    // Compares a value seen with the value expected and counts both.
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle write; returns just after the edge that took it, settled.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_strobe_in <= 1'b1;
        @(posedge core_clk_in);
        wr_strobe_in <= 1'b0;
        #1;
    endtask
    // One-cycle read; data is sampled in the single cycle it stands.
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_strobe_in <= 1'b1;
        @(posedge core_clk_in);
        rd_strobe_in <= 1'b0;
        #1;
        chk(name, rd_data_out, exp);
    endtask
    // One-cycle wake request; returns just after the edge that took it.
    task automatic wake();
        @(posedge core_clk_in);
        wake_event_in <= 1'b1;
        @(posedge core_clk_in);
        wake_event_in <= 1'b0;
        #1;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        reset_in = 1'b1;
        addr_in = 8'h00;
        wr_data_in = 16'h0000;
        wr_strobe_in = 1'b0;
        rd_strobe_in = 1'b0;
        wake_event_in = 1'b0;
        repeat (5) @(posedge core_clk_in);
        reset_in <= 1'b0;
        // Reset values, fixed extension value and the unmapped hole.
        rd(pmc_pkg::CTRL_OFS, 16'h0000, "ctrl reset");
        rd(pmc_pkg::BSE_OFS, 16'h00C0, "ext value");
        #20;
        chk("read idle", rd_data_out, 16'h0000);
        wr(pmc_pkg::BSE_OFS, 16'h0000);
        rd(pmc_pkg::BSE_OFS, 16'h00C0, "ext read only");
        rd(8'h50, 16'h0000, "unmapped");
        chk("wake idle", wake_n_out, 16'h0001);
        $display("test done: reset");
        // Power state codes D1 to D3hot, then interrupt masking and clearing.
        wr(pmc_pkg::IRQ_MASK_OFS, 16'h0001);
        for (int s = 1; s < 4; s++) begin
            wr(pmc_pkg::CTRL_OFS, 16'(s));
            chk("clk stop", sec_clk_stop_out, 16'(s == 3));
            chk("power off", sec_power_off_out, 16'h0000);
            rd(pmc_pkg::CTRL_OFS, 16'(s), "state");
        end
        rd(pmc_pkg::IRQ_STAT_OFS, 16'h0002, "irq status");
        chk("irq masked", irq_out, 16'h0000);
        wr(pmc_pkg::IRQ_MASK_OFS, 16'h0002);
        rd(pmc_pkg::IRQ_MASK_OFS, 16'h0002, "irq mask");
        chk("irq on", irq_out, 16'h0001);
        wr(pmc_pkg::IRQ_STAT_OFS, 16'h0002);
        @(posedge core_clk_in);
        #1;
        chk("irq cleared", irq_out, 16'h0000);
        $display("test done: states");
        // All ones: read-zero fields stay zero, the flag is not set by a one.
        wr(pmc_pkg::CTRL_OFS, 16'hFFFF);
        rd(pmc_pkg::CTRL_OFS, 16'h0103, "zero fields");
        // Leaving D3hot pulses the reset once; the register keeps its bits.
        wr(pmc_pkg::CTRL_OFS, 16'h0100);
        chk("reset pulse", func_reset_out, 16'h0001);
        chk("clk run", sec_clk_stop_out, 16'h0000);
        @(posedge core_clk_in);
        #1;
        chk("reset one cycle", func_reset_out, 16'h0000);
        rd(pmc_pkg::CTRL_OFS, 16'h0100, "kept over reset");
        $display("test done: leave d3hot");
        // Wake with enable set, then the write-one-to-clear behaviour.
        wake();
        chk("wake low", wake_n_out, 16'h0000);
        rd(pmc_pkg::CTRL_OFS, 16'h8100, "flag set");
        rd(pmc_pkg::IRQ_STAT_OFS, 16'h0007, "irq events");
        chk("irq wake", irq_out, 16'h0001);
        wr(pmc_pkg::IRQ_STAT_OFS, 16'h0007);
        rd(pmc_pkg::IRQ_STAT_OFS, 16'h0000, "irq clear all");
        wr(pmc_pkg::CTRL_OFS, 16'h0100);
        rd(pmc_pkg::CTRL_OFS, 16'h8100, "zero keeps flag");
        wr(pmc_pkg::CTRL_OFS, 16'h0000);
        #20;
        chk("enable off", wake_n_out, 16'h0001);
        rd(pmc_pkg::CTRL_OFS, 16'h8000, "flag stays");
        wr(pmc_pkg::CTRL_OFS, 16'h8000);
        rd(pmc_pkg::CTRL_OFS, 16'h0000, "flag cleared");
        // Wake while disabled still sets the flag; enabling then drives it.
        wake();
        chk("wake suppressed", wake_n_out, 16'h0001);
        rd(pmc_pkg::CTRL_OFS, 16'h8000, "flag no enable");
        wr(pmc_pkg::CTRL_OFS, 16'h0100);
        #20;
        chk("wake late", wake_n_out, 16'h0000);
        wr(pmc_pkg::CTRL_OFS, 16'h8100);
        #20;
        chk("wake released", wake_n_out, 16'h0001);
        rd(pmc_pkg::CTRL_OFS, 16'h0100, "release read");
        $display("test done: wake");
        end_sim();
    end
endmodule // pmc_regs_bench
